// >>> rtl/ufir_top.sv
// UART channel FIFOs, thresholds, level counters, compares and interrupt mask.
// Assumes an Avalon-MM host and receive and transmit shifters on sys_clk_i;
// io_pins_i come straight from pins.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`include "ufir_defs.svh"

// Notes on behaviour
// - Default trigger holds transmit flag low until all 256 slots free.
// - Transmit flag set below trigger occupancy, cleared when filled above it.
// - Transmitter raises its status bit 0 only while its flag is one.
// - Source reaches the interrupt only with status and mask set.
// - Mask bit 7 lets input changes raise an interrupt.
// - Mask bit 6 lets 64 idle bit times raise an interrupt.
// - Mask bit 5 lets address recognition changes interrupt.
// - Mask bit 4 lets flow-control characters interrupt.
// - Mask bit 3 lets counter/timer zero interrupt.
// - Mask bit 2 lets receiver break interrupt.
// - Mask bits 1 and 0 enable receive and transmit service.
// - Receive FIFO 11 bits by 256; status moves with its byte.
// - Entry bit 10 break, 9 framing, 8 parity, 7..0 data.
// - Character mode shows head status, updated on each data read.
// - Block mode accumulates errors since reset-error command.
// - Transmit FIFO 8 bits by 256; shifter ignores unused bits.
// - Receive threshold picks any of 256 levels, overriding default level of one.
// - Transmit threshold picks any of 256 levels, overriding mode level.
// - Receive fill count 8 bits; zero with data means 256.
// - Transmit empty count 8 bits; zero with space means 256.
// - Resume compare resets to 0x11, matched against received characters.
// - Pause compare resets to 0x13, matched against received characters.
// - Config bit 0 makes status reads return status ANDed with mask.
// - Status bits sit at their mask bits' positions.
module ufir_top
    import ufir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Avalon-MM slave
    input wire ufir_avl_req_t avl_req_i,
    output logic [31:0] avl_readdata_o,
    output logic avl_waitrequest_o,
    // Receive shifter side
    input wire logic rx_valid_i,
    input wire ufir_rx_ent_t rx_ent_i,
    output logic rx_ready_o,
    // Transmit shifter side
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // Event sources
    input wire logic bit_tick_i,
    input wire logic [1:0] io_pins_i,
    input wire logic break_evt_i,
    input wire logic ct_zero_i,
    input wire logic addr_evt_i,
    // Interrupt
    output logic interrupt_request_low_n_o
);

    // Bus state
    ufir_bus_st_t bus_st_r, bus_st_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Configuration
    logic [7:0] imask_r, imask_nxt;
    logic [7:0] rxthr_r, rxthr_nxt;
    logic rxthr_set_r, rxthr_set_nxt;
    logic [7:0] txthr_r, txthr_nxt;
    logic txthr_set_r, txthr_set_nxt;
    logic [7:0] resume_r, resume_nxt;
    logic [7:0] pause_r, pause_nxt;
    logic gcfg_r, gcfg_nxt;
    logic [7:0] mr0_r, mr0_nxt;
    logic [7:0] mr1_r, mr1_nxt;
    // Sticky event status, bits 7..2 of the status word
    logic [7:2] evt_r, evt_nxt;
    logic [2:0] err_acc_r, err_acc_nxt;
    logic [1:0] flow_rcv_r, flow_rcv_nxt;
    logic [6:0] wd_cnt_r, wd_cnt_nxt;
    logic irq_n_r, irq_n_nxt;
    // Pin synchroniser and change detector
    logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
    // FIFO pointers and occupancy
    logic [7:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
    logic [8:0] rx_cnt_r, rx_cnt_nxt;
    logic [7:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
    logic [8:0] tx_cnt_r, tx_cnt_nxt;
    // Storage
    ufir_rx_ent_t rx_mem [0:255];
    logic [7:0] tx_mem [0:255];

    // Decoded helpers
    logic acc, acc_rd, acc_wr;
    logic [7:0] adr;
    logic rx_push, rx_pop, tx_push, tx_pop;
    logic [8:0] tx_free, rx_lvl, tx_lvl;
    logic rx_flag, tx_flag, tx_space, rx_data;
    logic [7:0] interrupt_status, isr_rd;
    logic [2:0] head_err, err_show;
    logic pin_chg;

    // Handshakes to the shifters, bus wait and read data, interrupt output
    assign rx_ready_o = (rx_cnt_r != `UFIR_DEPTH);
    assign tx_valid_o = (tx_cnt_r != 9'd0);
    assign tx_data_o = tx_mem[tx_rp_r];
    assign avl_waitrequest_o = (avl_req_i.read | avl_req_i.write) & (bus_st_r != UFIR_BUS_DONE);
    assign avl_readdata_o = rdata_r;
    assign interrupt_request_low_n_o = irq_n_r;

    // Access decode and FIFO transfers
    assign acc = (bus_st_r == UFIR_BUS_IDLE) & (avl_req_i.read | avl_req_i.write);
    assign acc_rd = acc & avl_req_i.read;
    assign acc_wr = acc & avl_req_i.write;
    assign adr = avl_req_i.address;
    assign rx_push = rx_valid_i & rx_ready_o;
    assign rx_pop = acc_rd & (adr == `UFIR_OFS_RECEIVE_FIFO_PORT) & (rx_cnt_r != 9'd0);
    assign tx_push = acc_wr & (adr == `UFIR_OFS_TRANSMIT_FIFO_PORT) & (tx_cnt_r != `UFIR_DEPTH);
    assign tx_pop = tx_valid_o & tx_ready_i;

    // Service levels and flags
    assign tx_free = `UFIR_DEPTH - tx_cnt_r;
    assign rx_data = (rx_cnt_r != 9'd0);
    assign tx_space = (tx_cnt_r != `UFIR_DEPTH);
    always_comb begin
        rx_lvl = 9'd1;
        if (rxthr_set_r) begin
            rx_lvl = (rxthr_r == 8'h00) ? `UFIR_DEPTH : {1'b0, rxthr_r};
        end
        tx_lvl = `UFIR_DEPTH;
        if (txthr_set_r) begin
            tx_lvl = (txthr_r == 8'h00) ? `UFIR_DEPTH : {1'b0, txthr_r};
        end else if (mr0_r[`UFIR_MR0_TXTRIG_HI:`UFIR_MR0_TXTRIG_LO] == 2'b01) begin
            tx_lvl = `UFIR_TXLVL_01;
        end else if (mr0_r[`UFIR_MR0_TXTRIG_HI:`UFIR_MR0_TXTRIG_LO] == 2'b10) begin
            tx_lvl = `UFIR_TXLVL_10;
        end else if (mr0_r[`UFIR_MR0_TXTRIG_HI:`UFIR_MR0_TXTRIG_LO] == 2'b11) begin
            tx_lvl = `UFIR_TXLVL_11;
        end
    end
    assign rx_flag = rx_data & (rx_cnt_r >= rx_lvl);
    assign tx_flag = tx_space & (tx_free >= tx_lvl);

    // Status word, positions match the mask
    assign interrupt_status = {evt_r, rx_flag, tx_flag};
    assign isr_rd = gcfg_r ? (interrupt_status & imask_r) : interrupt_status;

    // Head entry status or accumulated block status
    assign head_err = rx_data ? {rx_mem[rx_rp_r].brk, rx_mem[rx_rp_r].fe,
                                 rx_mem[rx_rp_r].pe} : 3'b000;
    assign err_show = mr1_r[`UFIR_MR1_BLOCKERR] ? err_acc_r : head_err;

    // Pin change seen after two synchronising stages
    assign pin_chg = |(pin_s2_r ^ pin_s3_r);

    // Bus slave, register writes and read data
    always_comb begin
        bus_st_nxt = UFIR_BUS_IDLE;
        if (acc) begin
            bus_st_nxt = UFIR_BUS_DONE;
        end
        imask_nxt = imask_r;
        rxthr_nxt = rxthr_r;
        rxthr_set_nxt = rxthr_set_r;
        txthr_nxt = txthr_r;
        txthr_set_nxt = txthr_set_r;
        resume_nxt = resume_r;
        pause_nxt = pause_r;
        gcfg_nxt = gcfg_r;
        mr0_nxt = mr0_r;
        mr1_nxt = mr1_r;
        if (acc_wr) begin
            if (adr == `UFIR_OFS_IMASK) begin
                imask_nxt = avl_req_i.writedata[7:0];
            end else if (adr == `UFIR_OFS_RXTHR) begin
                rxthr_nxt = avl_req_i.writedata[7:0];
                rxthr_set_nxt = 1'b1;
            end else if (adr == `UFIR_OFS_TXTHR) begin
                txthr_nxt = avl_req_i.writedata[7:0];
                txthr_set_nxt = 1'b1;
            end else if (adr == `UFIR_OFS_RESUME) begin
                resume_nxt = avl_req_i.writedata[7:0];
            end else if (adr == `UFIR_OFS_PAUSE) begin
                pause_nxt = avl_req_i.writedata[7:0];
            end else if (adr == `UFIR_OFS_GCFG) begin
                gcfg_nxt = avl_req_i.writedata[`UFIR_GCFG_RDMASK];
            end else if (adr == `UFIR_OFS_MR0) begin
                mr0_nxt = avl_req_i.writedata[7:0];
            end else if (adr == `UFIR_OFS_MR1) begin
                mr1_nxt = avl_req_i.writedata[7:0];
            end
        end
        rdata_nxt = rdata_r;
        if (acc_rd) begin
            rdata_nxt = 32'h0000_0000;
            if (adr == `UFIR_OFS_IMASK) begin
                rdata_nxt[7:0] = imask_r;
            end else if (adr == `UFIR_OFS_ISTAT) begin
                rdata_nxt[7:0] = isr_rd;
            end else if (adr == `UFIR_OFS_RECEIVE_FIFO_PORT) begin
                if (rx_data) begin
                    rdata_nxt[10:0] = rx_mem[rx_rp_r];
                end
            end else if (adr == `UFIR_OFS_RXTHR) begin
                rdata_nxt[7:0] = rxthr_r;
            end else if (adr == `UFIR_OFS_RXFILL) begin
                rdata_nxt[7:0] = rx_cnt_r[7:0];
            end else if (adr == `UFIR_OFS_TXTHR) begin
                rdata_nxt[7:0] = txthr_r;
            end else if (adr == `UFIR_OFS_TXEMPTY) begin
                rdata_nxt[7:0] = tx_free[7:0];
            end else if (adr == `UFIR_OFS_RESUME) begin
                rdata_nxt[7:0] = resume_r;
            end else if (adr == `UFIR_OFS_PAUSE) begin
                rdata_nxt[7:0] = pause_r;
            end else if (adr == `UFIR_OFS_GCFG) begin
                rdata_nxt[0] = gcfg_r;
            end else if (adr == `UFIR_OFS_MR0) begin
                rdata_nxt[7:0] = mr0_r;
            end else if (adr == `UFIR_OFS_MR1) begin
                rdata_nxt[7:0] = mr1_r;
            end else if (adr == `UFIR_OFS_CHSTAT) begin
                rdata_nxt[7:5] = err_show;
                rdata_nxt[2] = tx_space;
                rdata_nxt[1] = ~rx_ready_o;
                rdata_nxt[0] = rx_data;
            end else if (adr == `UFIR_OFS_INPORT) begin
                rdata_nxt[1:0] = pin_s2_r;
            end else if (adr == `UFIR_OFS_FLOWST) begin
                rdata_nxt[7:6] = flow_rcv_r;
            end
        end
    end

    // Bus and configuration registers
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_st_r <= UFIR_BUS_IDLE;
            rdata_r <= 32'h0000_0000;
            imask_r <= 8'h00;
            rxthr_r <= 8'h00;
            rxthr_set_r <= 1'b0;
            txthr_r <= 8'h00;
            txthr_set_r <= 1'b0;
            resume_r <= `UFIR_RST_RESUME;
            pause_r <= `UFIR_RST_PAUSE;
            gcfg_r <= 1'b0;
            mr0_r <= 8'h00;
            mr1_r <= 8'h00;
        end else begin
            bus_st_r <= bus_st_nxt;
            rdata_r <= rdata_nxt;
            imask_r <= imask_nxt;
            rxthr_r <= rxthr_nxt;
            rxthr_set_r <= rxthr_set_nxt;
            txthr_r <= txthr_nxt;
            txthr_set_r <= txthr_set_nxt;
            resume_r <= resume_nxt;
            pause_r <= pause_nxt;
            gcfg_r <= gcfg_nxt;
            mr0_r <= mr0_nxt;
            mr1_r <= mr1_nxt;
        end
    end

    // FIFO pointers and occupancy
    always_comb begin
        rx_wp_nxt = rx_push ? rx_wp_r + 8'd1 : rx_wp_r;
        rx_rp_nxt = rx_pop ? rx_rp_r + 8'd1 : rx_rp_r;
        rx_cnt_nxt = rx_cnt_r;
        if (rx_push & ~rx_pop) begin
            rx_cnt_nxt = rx_cnt_r + 9'd1;
        end else if (rx_pop & ~rx_push) begin
            rx_cnt_nxt = rx_cnt_r - 9'd1;
        end
        tx_wp_nxt = tx_push ? tx_wp_r + 8'd1 : tx_wp_r;
        tx_rp_nxt = tx_pop ? tx_rp_r + 8'd1 : tx_rp_r;
        tx_cnt_nxt = tx_cnt_r;
        if (tx_push & ~tx_pop) begin
            tx_cnt_nxt = tx_cnt_r + 9'd1;
        end else if (tx_pop & ~tx_push) begin
            tx_cnt_nxt = tx_cnt_r - 9'd1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_wp_r <= 8'h00;
            rx_rp_r <= 8'h00;
            rx_cnt_r <= 9'h000;
            tx_wp_r <= 8'h00;
            tx_rp_r <= 8'h00;
            tx_cnt_r <= 9'h000;
        end else begin
            rx_wp_r <= rx_wp_nxt;
            rx_rp_r <= rx_rp_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tx_wp_r <= tx_wp_nxt;
            tx_rp_r <= tx_rp_nxt;
            tx_cnt_r <= tx_cnt_nxt;
        end
    end

    // FIFO storage, byte and its status written together
    always_ff @(posedge sys_clk_i) begin
        if (rx_push) begin
            rx_mem[rx_wp_r] <= rx_ent_i;
        end
        if (tx_push) begin
            tx_mem[tx_wp_r] <= avl_req_i.writedata[7:0];
        end
    end

    // Sticky events, error accumulation, watchdog and interrupt; a set wins over a clear
    always_comb begin
        evt_nxt = evt_r;
        err_acc_nxt = err_acc_r;
        flow_rcv_nxt = flow_rcv_r;
        wd_cnt_nxt = wd_cnt_r;
        // Clears from commands and reads
        if (acc_wr & (adr == `UFIR_OFS_CMD)) begin
            if (avl_req_i.writedata[7:0] == `UFIR_CMD_RST_ERR) begin
                err_acc_nxt = 3'b000;
            end else if (avl_req_i.writedata[7:0] == `UFIR_CMD_RST_BRK) begin
                evt_nxt[`UFIR_ISR_BRK] = 1'b0;
            end else if (avl_req_i.writedata[7:0] == `UFIR_CMD_STOP_CT) begin
                evt_nxt[`UFIR_ISR_CT] = 1'b0;
            end else if (avl_req_i.writedata[7:0] == `UFIR_CMD_RST_ADDR) begin
                evt_nxt[`UFIR_ISR_ADDR] = 1'b0;
            end
        end
        if (acc_rd & (adr == `UFIR_OFS_INPORT)) begin
            evt_nxt[`UFIR_ISR_COS] = 1'b0;
        end
        if (acc_rd & (adr == `UFIR_OFS_FLOWST)) begin
            evt_nxt[`UFIR_ISR_FLOW] = 1'b0;
            flow_rcv_nxt = 2'b00;
        end
        if (acc_rd & (adr == `UFIR_OFS_RECEIVE_FIFO_PORT)) begin
            evt_nxt[`UFIR_ISR_WD] = 1'b0;
        end
        // Watchdog restarts on every receive FIFO event
        if (rx_push | (acc_rd & (adr == `UFIR_OFS_RECEIVE_FIFO_PORT))) begin
            wd_cnt_nxt = 7'd0;
        end else if (bit_tick_i & (wd_cnt_r != `UFIR_WD_BITS)) begin
            wd_cnt_nxt = wd_cnt_r + 7'd1;
        end
        if (bit_tick_i & (wd_cnt_r == `UFIR_WD_BITS - 7'd1) & rx_data & ~rx_push) begin
            evt_nxt[`UFIR_ISR_WD] = 1'b1;
        end
        // Sets from sources
        if (pin_chg) begin
            evt_nxt[`UFIR_ISR_COS] = 1'b1;
        end
        if (addr_evt_i) begin
            evt_nxt[`UFIR_ISR_ADDR] = 1'b1;
        end
        if (ct_zero_i) begin
            evt_nxt[`UFIR_ISR_CT] = 1'b1;
        end
        if (break_evt_i) begin
            evt_nxt[`UFIR_ISR_BRK] = 1'b1;
        end
        if (rx_push) begin
            err_acc_nxt = err_acc_nxt | {rx_ent_i.brk, rx_ent_i.fe, rx_ent_i.pe};
            if (rx_ent_i.data == resume_r) begin
                flow_rcv_nxt[1] = 1'b1;
                evt_nxt[`UFIR_ISR_FLOW] = 1'b1;
            end
            if (rx_ent_i.data == pause_r) begin
                flow_rcv_nxt[0] = 1'b1;
                evt_nxt[`UFIR_ISR_FLOW] = 1'b1;
            end
        end
        // Masked sources drive the active-low request
        irq_n_nxt = ~|(interrupt_status & imask_r);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evt_r <= 6'h00;
            err_acc_r <= 3'b000;
            flow_rcv_r <= 2'b00;
            wd_cnt_r <= 7'h00;
            irq_n_r <= 1'b1;
            pin_s1_r <= 2'b00;
            pin_s2_r <= 2'b00;
            pin_s3_r <= 2'b00;
        end else begin
            evt_r <= evt_nxt;
            err_acc_r <= err_acc_nxt;
            flow_rcv_r <= flow_rcv_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            irq_n_r <= irq_n_nxt;
            pin_s1_r <= io_pins_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

endmodule : ufir_top

// >>> rtl/ufir_defs.svh
// Offsets, field positions, reset values and counts of the FIFO block.
// Assumes inclusion by bare name from the top module.
`ifndef UFIR_DEFS_SVH
`define UFIR_DEFS_SVH

// Register byte offsets, one aligned word each
`define UFIR_OFS_IMASK 8'h00
`define UFIR_OFS_ISTAT 8'h04
`define UFIR_OFS_RECEIVE_FIFO_PORT 8'h08
`define UFIR_OFS_TRANSMIT_FIFO_PORT 8'h0c
`define UFIR_OFS_RXTHR 8'h10
`define UFIR_OFS_RXFILL 8'h14
`define UFIR_OFS_TXTHR 8'h18
`define UFIR_OFS_TXEMPTY 8'h1c
`define UFIR_OFS_RESUME 8'h20
`define UFIR_OFS_PAUSE 8'h24
`define UFIR_OFS_GCFG 8'h28
`define UFIR_OFS_MR0 8'h2c
`define UFIR_OFS_MR1 8'h30
`define UFIR_OFS_CMD 8'h34
`define UFIR_OFS_CHSTAT 8'h38
`define UFIR_OFS_INPORT 8'h3c
`define UFIR_OFS_FLOWST 8'h40

// Reset values
`define UFIR_RST_RESUME 8'h11
`define UFIR_RST_PAUSE 8'h13

// Command codes
`define UFIR_CMD_RST_ERR 8'h04
`define UFIR_CMD_RST_BRK 8'h05
`define UFIR_CMD_STOP_CT 8'h0b
`define UFIR_CMD_RST_ADDR 8'h1b

// Interrupt status and mask bit positions
`define UFIR_ISR_TX 0
`define UFIR_ISR_RX 1
`define UFIR_ISR_BRK 2
`define UFIR_ISR_CT 3
`define UFIR_ISR_FLOW 4
`define UFIR_ISR_ADDR 5
`define UFIR_ISR_WD 6
`define UFIR_ISR_COS 7

// Mode and config field positions
`define UFIR_MR0_TXTRIG_HI 5
`define UFIR_MR0_TXTRIG_LO 4
`define UFIR_MR1_BLOCKERR 5
`define UFIR_GCFG_RDMASK 0

// FIFO depth and transmit trigger free-space levels
`define UFIR_DEPTH 9'd256
`define UFIR_TXLVL_01 9'd192
`define UFIR_TXLVL_10 9'd128
`define UFIR_TXLVL_11 9'd1

// Receiver watchdog in idle bit times
`define UFIR_WD_BITS 7'd64

`endif

// >>> rtl/ufir_pkg.sv
// Types shared by the UART FIFO and interrupt block.
// Assumes the defs header is on the include path.
package ufir_pkg;

    // One receive FIFO entry: error status travels with its byte
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } ufir_rx_ent_t;

    // Avalon-MM request from the host
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } ufir_avl_req_t;

    // Bus slave states
    typedef enum logic [1:0] {
        UFIR_BUS_IDLE = 2'b01,
        UFIR_BUS_DONE = 2'b10
    } ufir_bus_st_t;

endpackage : ufir_pkg

// >>> verification/ufir_top_assertions.sv
// Port-level checker for the UART FIFO and interrupt block.
// Assumes bind into ufir_top; one clock.
`timescale 1ns/10ps
module ufir_checker
    import ufir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Bus
    input wire ufir_avl_req_t avl_req_i,
    input wire logic [31:0] avl_readdata_o,
    input wire logic avl_waitrequest_o,
    // Transmit stream and interrupt
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic interrupt_request_low_n_o
);
    logic mask_nz_r, mask_nz_nxt;
    logic req_w;
    logic [7:0] adr_w;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    // Request shorthands
    assign req_w = avl_req_i.read || avl_req_i.write;
    assign adr_w = avl_req_i.address;

    // Last taken mask write non-zero
    always_comb begin
        mask_nz_nxt = mask_nz_r;
        if (avl_req_i.write && avl_waitrequest_o && adr_w == 8'h00) begin
            mask_nz_nxt = |avl_req_i.writedata[7:0];
        end
    end

    // Mask tracker register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mask_nz_r <= 1'b0;
        end else begin
            mask_nz_r <= mask_nz_nxt;
        end
    end

    a_wait_first: assert property (req_w && !$past(req_w) |-> avl_waitrequest_o)
        else $error("no wait state");
    a_wait_one: assert property (req_w && avl_waitrequest_o |=> !avl_waitrequest_o)
        else $error("bus answer late");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx head lost");
    a_tx_drain: assert property ($fell(tx_valid_o) |-> $past(tx_ready_i))
        else $error("tx drained without pop");
    a_tx_fill: assert property ($rose(tx_valid_o) |-> $past(avl_req_i.write && adr_w == 8'h0c))
        else $error("tx filled without push");
    a_irq_gated: assert property (!interrupt_request_low_n_o |-> mask_nz_r || $past(mask_nz_r))
        else $error("irq while masked");
    a_empty_count: assert property (avl_req_i.read && !avl_waitrequest_o && adr_w == 8'h1c && $past(!tx_valid_o)
        |-> avl_readdata_o == 32'h0)
        else $error("empty count wrong");
    a_rdata_hold: assert property (!avl_req_i.read |=> $stable(avl_readdata_o))
        else $error("read data moved");
endmodule : ufir_checker

bind ufir_top ufir_checker u_ufir_checker (.*);

// >>> verification/ufir_line_model.sv
// Line-side model: receive and transmit shifters.
// Assumes bench controls on the same clock.
`timescale 1ns/10ps
module ufir_line_model
    import ufir_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Block streams
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output ufir_rx_ent_t rx_ent_o,
    // Bench controls
    input wire logic push_i,
    input wire ufir_rx_ent_t push_ent_i,
    input wire logic [8:0] take_i,
    input wire logic slow_i,
    output logic [8:0] credit_o,
    output logic [7:0] last_o
);
    logic pace_r;

    // Slow mode accepts only on alternate cycles
    assign tx_ready_o = (credit_o != 9'h000) && (pace_r || !slow_i);

    // Credits, taken bytes and offered entries
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            credit_o <= 9'h000;
            pace_r <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_ent_o <= '0;
            last_o <= 8'h00;
        end else begin
            pace_r <= ~pace_r;
            if (take_i != 9'h000) begin
                credit_o <= take_i;
            end else if (tx_valid_i && tx_ready_o) begin
                credit_o <= credit_o - 9'h001;
                last_o <= tx_data_i;
            end
            if (push_i) begin
                rx_valid_o <= 1'b1;
                rx_ent_o <= push_ent_i;
            end else if (rx_valid_o && rx_ready_i) begin
                rx_valid_o <= 1'b0;
                rx_ent_o <= ~rx_ent_o; // Released lines show garbage
            end
        end
    end
endmodule : ufir_line_model

// >>> verification/tb_top.sv
// Self-checking bench for ufir_top with a line-side model.
// Assumes the checker binds itself; expectations flow through one queue.
`timescale 1ns/10ps
module tb_top;
    import ufir_pkg::*;
    typedef struct packed {logic [1:0] src; logic [31:0] val;} ufir_note_t;
    logic clk = 0, rst_n = 0, rxv, rxr, txv, txr, tick = 0, interrupt_request_low, push = 0, slow = 0, wreq;
    logic [31:0] rdata;
    logic [7:0] txd, last, v;
    logic [8:0] take = 0, credit;
    logic [2:0] evt = 0;
    logic [1:0] pins = 0;
    ufir_avl_req_t req = '0;
    ufir_rx_ent_t rxe, pent = '0;
    ufir_note_t notes[$];
    logic [7:0] ra [5] = '{8'h00, 8'h10, 8'h18, 8'h20, 8'h24};
    int failures = 0, num_checks = 0, cycles = 0;

    ufir_top u_ufir_top (.sys_clk_i(clk), .rstn_i(rst_n), .avl_req_i(req),
        .avl_readdata_o(rdata), .avl_waitrequest_o(wreq), .rx_valid_i(rxv),
        .rx_ent_i(rxe), .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
        .tx_ready_i(txr), .bit_tick_i(tick), .io_pins_i(pins), .break_evt_i(evt[0]),
        .ct_zero_i(evt[1]), .addr_evt_i(evt[2]), .interrupt_request_low_n_o(interrupt_request_low));
    ufir_line_model u_ufir_line_model (.clk_i(clk), .rstn_i(rst_n), .tx_valid_i(txv),
        .tx_data_i(txd), .tx_ready_o(txr), .rx_ready_i(rxr), .rx_valid_o(rxv),
        .rx_ent_o(rxe), .push_i(push), .push_ent_i(pent), .take_i(take),
        .slow_i(slow), .credit_o(credit), .last_o(last));

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // Watcher: oldest note against the outputs
    always @(negedge clk) begin
        if (notes.size() != 0) begin
            if (notes[0].src != 2'h0) begin
                check({24'h0, notes[0].src == 2'h1 ? {7'h0, interrupt_request_low} : last}, notes[0].val);
                void'(notes.pop_front());
            end else if (req.read && !wreq) begin
                check(rdata, notes[0].val);
                void'(notes.pop_front());
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, writedata: d};
        do @(posedge clk); while (wreq);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back('{2'h0, e});
        wr(a, 32'h0, 1'b0);
    endtask : rd

    task automatic note(input logic [1:0] s, input logic [31:0] e);
        repeat (2) @(posedge clk);
        notes.push_back('{s, e});
    endtask : note

    task automatic drain(input logic [8:0] n);
        @(posedge clk);
        take <= n;
        @(posedge clk);
        take <= 9'h000;
        do @(posedge clk); while (credit != 9'h000);
    endtask : drain

    task automatic send(input logic [10:0] e);
        @(posedge clk);
        push <= 1'b1;
        pent <= e;
        @(posedge clk);
        push <= 1'b0;
        do @(negedge clk); while (rxv);
    endtask : send

    task automatic pulse_tick(input int k);
        @(posedge clk);
        if (k < 0) tick <= 1'b1;
        else evt[k] <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        evt <= 3'h0;
    endtask : pulse_tick

    task automatic ev(input int k, input int b, input logic [31:0] c);
        pulse_tick(k);
        note(1, 1);
        rd(8'h04, 32'h1 | (32'h1 << b));
        wr(8'h00, 32'h1 << b);
        note(1, 0);
        wr(8'h34, c);
        note(1, 1);
        rd(8'h04, 32'h1);
        wr(8'h00, 32'h0);
    endtask : ev

    // Main sequence
    initial begin
        void'($urandom(69));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h20, 32'h11);
        rd(8'h24, 32'h13);
        rd(8'h14, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h80, 32'h0);
        rd(8'h04, 32'h1);
        wr(8'h0c, 32'h1a5);
        rd(8'h04, 32'h0);
        rd(8'h1c, 32'hff);
        wr(8'h00, 32'h1);
        note(1, 1);
        drain(9'd1);
        note(2, 32'ha5);
        note(1, 0);
        wr(8'h2c, 32'h30);
        for (int i = 0; i < 256; i++) wr(8'h0c, i);
        rd(8'h04, 32'h0);
        note(1, 1);
        rd(8'h1c, 32'h0);
        rd(8'h38, 32'h0);
        wr(8'h18, 32'h10);
        drain(9'd15);
        note(1, 1);
        rd(8'h1c, 32'hf);
        drain(9'd1);
        note(1, 0);
        note(2, 32'hf);
        slow <= 1'b1;
        drain(9'd240);
        note(2, 32'hff);
        slow <= 1'b0;
        wr(8'h00, 32'h2);
        send(11'h55a);
        send(11'h2c3);
        note(1, 0);
        rd(8'h14, 32'h2);
        rd(8'h38, 32'ha5);
        rd(8'h08, 32'h55a);
        rd(8'h38, 32'h45);
        rd(8'h08, 32'h2c3);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        note(1, 1);
        wr(8'h30, 32'h20);
        send(11'h55a);
        send(11'h2c3);
        rd(8'h08, 32'h55a);
        rd(8'h08, 32'h2c3);
        rd(8'h38, 32'he4);
        wr(8'h34, 32'h4);
        rd(8'h38, 32'h4);
        wr(8'h30, 32'h0);
        wr(8'h10, 32'h2);
        send(11'h0a1);
        rd(8'h04, 32'h1);
        send(11'h0a2);
        rd(8'h04, 32'h3);
        repeat (63) pulse_tick(-1);
        rd(8'h14, 32'h2);
        pulse_tick(-1);
        rd(8'h04, 32'h43);
        wr(8'h00, 32'h40);
        note(1, 0);
        rd(8'h08, 32'h0a1);
        rd(8'h08, 32'h0a2);
        note(1, 1);
        wr(8'h00, 32'h10);
        send(11'h013);
        note(1, 0);
        rd(8'h40, 32'h40);
        note(1, 1);
        send(11'h011);
        rd(8'h40, 32'h80);
        rd(8'h08, 32'h013);
        rd(8'h08, 32'h011);
        wr(8'h00, 32'h0);
        ev(0, 2, 32'h05);
        ev(1, 3, 32'h0b);
        ev(2, 5, 32'h1b);
        wr(8'h00, 32'h80);
        pins <= 2'b01;
        repeat (4) @(posedge clk);
        note(1, 0);
        rd(8'h3c, 32'h1);
        note(1, 1);
        wr(8'h28, 32'h1);
        wr(8'h00, 32'h2);
        rd(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        rd(8'h04, 32'h1);
        wr(8'h28, 32'h0);
        foreach (ra[i]) begin
            v = 8'($urandom);
            wr(ra[i], {24'h0, v});
            rd(ra[i], {24'h0, v});
        end
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule : tb_top
